// ---- rtl/scr_clock_reset.sv ----
// system clock divider, peripheral clock gates, reset merge, bus decode
// assumes all inputs synchronous to clk; clocks leave as enable pulses
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_clock_reset import scr_pkg::*; #(
   parameter int NGATE = 16
) (
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire scr_rst_src_t       rstSrc,
   input  wire logic [2:0]         divSelReq,
   input  wire logic [NGATE-1:0]   gateReq,
   input  wire scr_bus_req_t       busReq,
   output logic                    sysClkEn,
   output logic [NGATE-1:0]        periphClkEn,
   output logic                    tempClkEn,
   output logic                    timerClkEn,
   output logic [2:0]              divSel,
   output logic                    sysResetN,
   output logic                    cpuRestart,
   output logic [31:0]             bootAddr,
   output logic [2:0]              rstCause,
   output logic [31:0]             apbSel,
   output logic                    gpioSel,
   output logic                    busErr
);

   localparam int HOLD_CYC = `SCR_RST_HOLD_CYC;

   if (NGATE < 1 || NGATE > 32) begin : g_badNgate
      $error("scr_clock_reset: NGATE must be 1..32");
   end

   function automatic logic [`SCR_DIV_CNT_W-1:0] divMask(
      input logic [2:0] sel);
      divMask = `SCR_DIV_CNT_W'((8'h01 << sel) - 8'h01);
   endfunction : divMask

   function automatic logic wordOk(input scr_bus_req_t r);
      wordOk = (r.size == `SCR_SIZE_WORD) && (r.addr[1:0] == 2'h0);
   endfunction : wordOk

   logic                      oscTick;
   logic                      tmrTick;
   logic [`SCR_DIV_CNT_W-1:0] divCnt_r;
   logic                      sysTick;
   logic [NGATE-1:0]          gate_r;
   logic [3:0]                tempCnt_r;
   scr_rst_state_t            rstState_r;
   logic [7:0]                holdCnt_r;
   logic                      anyRst;
   logic                      inApb;
   logic                      inGpio;

   // separate sources so the timer never depends on the divider
   scr_rate_gen #(
      .NUM   (`SCR_SYS_OSC_HZ / 1000),
      .DEN   (`SCR_CLK_HZ / 1000),
      .ACC_W (24)
   ) u_sysOsc (
      .clk  (clk),
      .rstn (rstn),
      .tick (oscTick)
   );

   scr_rate_gen #(
      .NUM   (`SCR_TMR_OSC_HZ),
      .DEN   (`SCR_CLK_HZ),
      .ACC_W (24)
   ) u_tmrOsc (
      .clk  (clk),
      .rstn (rstn),
      .tick (tmrTick)
   );

   assign anyRst = !rstSrc.pinN || rstSrc.wdt || rstSrc.sw;
   assign sysTick = oscTick &&
                    ((divCnt_r & divMask(divSel)) == divMask(divSel));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         divCnt_r <= '0;
      else if (oscTick)
         divCnt_r <= divCnt_r + `SCR_DIV_CNT_W'(1);
   end

   // setting only moves on a pulse of the current rate or in reset hold; the next
   // period is a whole one when the new rate is the same or faster, and may be short when slower
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         divSel <= `SCR_DIV_RESET;
      else if (rstState_r == RST_HOLD)
         divSel <= `SCR_DIV_RESET;
      else if (sysTick)
         divSel <= divSelReq;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         gate_r <= NGATE'(`SCR_GATE_RESET);
      else if (rstState_r == RST_HOLD)
         gate_r <= NGATE'(`SCR_GATE_RESET);
      else if (sysTick)
         gate_r <= gateReq;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sysClkEn    <= 1'b0;
         periphClkEn <= '0;
      end else begin
         sysClkEn    <= sysTick;
         periphClkEn <= gate_r & {NGATE{sysTick}};
      end
   end

   // fixed divide of the oscillator, blind to the divider setting
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tempCnt_r <= 4'h0;
         tempClkEn <= 1'b0;
      end else if (oscTick) begin
         if (tempCnt_r == `SCR_TEMP_DIV - 4'h1) begin
            tempCnt_r <= 4'h0;
            tempClkEn <= 1'b1;
         end else begin
            tempCnt_r <= tempCnt_r + 4'h1;
            tempClkEn <= 1'b0;
         end
      end else begin
         tempClkEn <= 1'b0;
      end
   end

   // no input reaches this path, so software cannot stop the timer clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         timerClkEn <= 1'b0;
      else
         timerClkEn <= tmrTick;
   end

   // any source restarts the hold; the system leaves it at address 0
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstState_r <= RST_HOLD;
         holdCnt_r  <= 8'(HOLD_CYC);
         sysResetN  <= 1'b0;
         cpuRestart <= 1'b0;
      end else begin
         cpuRestart <= 1'b0;
         if (anyRst) begin
            rstState_r <= RST_HOLD;
            holdCnt_r  <= 8'(HOLD_CYC);
            sysResetN  <= 1'b0;
         end else begin
            unique case (rstState_r)
               RST_HOLD: begin
                  if (holdCnt_r == 8'h01) begin
                     rstState_r <= RST_RUN;
                     sysResetN  <= 1'b1;
                     cpuRestart <= 1'b1;
                  end else begin
                     holdCnt_r <= holdCnt_r - 8'h01;
                  end
               end
               RST_RUN: begin
                  sysResetN <= 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         bootAddr <= `SCR_BOOT_ADDR;
      else
         bootAddr <= `SCR_BOOT_ADDR;
   end

   // cause is replaced by a fresh reset out of run, gathered during hold
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         rstCause <= 3'h0;
      else if (anyRst && rstState_r == RST_RUN)
         rstCause <= {!rstSrc.pinN, rstSrc.wdt, rstSrc.sw};
      else if (anyRst)
         rstCause <= rstCause | {!rstSrc.pinN, rstSrc.wdt, rstSrc.sw};
   end

   assign inApb  = busReq.addr[31:`SCR_APB_SPAN_BITS] ==
                   (32-`SCR_APB_SPAN_BITS)'(
                      `SCR_APB_BASE >> `SCR_APB_SPAN_BITS);
   assign inGpio = busReq.addr[31:`SCR_GPIO_SPAN_BITS] ==
                   (32-`SCR_GPIO_SPAN_BITS)'(
                      `SCR_GPIO_BASE >> `SCR_GPIO_SPAN_BITS);

   // byte and halfword accesses select nothing and are flagged instead
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         apbSel  <= 32'h0000_0000;
         gpioSel <= 1'b0;
         busErr  <= 1'b0;
      end else begin
         apbSel  <= 32'h0000_0000;
         gpioSel <= 1'b0;
         busErr  <= 1'b0;
         if (busReq.valid) begin
            if (!wordOk(busReq) || !(inApb || inGpio))
               busErr <= 1'b1;
            else if (inGpio)
               gpioSel <= 1'b1;
            else
               apbSel <= 32'h0000_0001 <<
                  busReq.addr[`SCR_APB_SPAN_BITS-1:`SCR_SLOT_BITS];
         end
      end
   end

   // first tick lands two cycles after reset; the cadence holds from then on
   logic       oscLive_r;
   logic [9:0] tmrGap_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         oscLive_r <= 1'b0;
      else if (oscTick)
         oscLive_r <= 1'b1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         tmrGap_r <= 10'h000;
      else if (timerClkEn)
         tmrGap_r <= 10'h000;
      else if (tmrGap_r != 10'h3FF)
         tmrGap_r <= tmrGap_r + 10'h001;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_oscRate;
      oscLive_r && !oscTick |=> oscTick;
   endproperty
   a_oscRate: assert property (p_oscRate)
      else $error("system oscillator tick missing twice in a row");

   property p_divAlign;
      sysClkEn |-> (($past(divCnt_r) & divMask($past(divSel))) ==
                    divMask($past(divSel)));
   endproperty
   a_divAlign: assert property (p_divAlign)
      else $error("system pulse not on a divider boundary");

   property p_tmrAlive;
      tmrGap_r < 10'h140;
   endproperty
   a_tmrAlive: assert property (p_tmrAlive)
      else $error("timer clock stopped");

   property p_divReset;
      !sysResetN |=> divSel == `SCR_DIV_RESET;
   endproperty
   a_divReset: assert property (p_divReset)
      else $error("divider not at default during reset");

   property p_gateSub;
      (|periphClkEn) |-> sysClkEn;
   endproperty
   a_gateSub: assert property (p_gateSub)
      else $error("peripheral pulse without system pulse");

   property p_tempGap;
      tempClkEn |=> !tempClkEn [*7];
   endproperty
   a_tempGap: assert property (p_tempGap)
      else $error("temperature clock faster than fixed rate");

   property p_rstSrc;
      anyRst |=> !sysResetN;
   endproperty
   a_rstSrc: assert property (p_rstSrc)
      else $error("reset source did not hold system reset");

   property p_wordOnly;
      busReq.valid && busReq.size != `SCR_SIZE_WORD
         |=> busErr && apbSel == 32'h0 && !gpioSel;
   endproperty
   a_wordOnly: assert property (p_wordOnly)
      else $error("narrow access was not refused");

   property p_slot;
      busReq.valid && wordOk(busReq) && inApb |=>
         apbSel == 32'h1 << $past(busReq.addr[18:14]);
   endproperty
   a_slot: assert property (p_slot)
      else $error("wrong peripheral slot selected");

   property p_gpioAlone;
      gpioSel |-> apbSel == 32'h0 && !busErr;
   endproperty
   a_gpioAlone: assert property (p_gpioAlone)
      else $error("gpio select overlaps another select");

   property p_hold;
      $fell(sysResetN) |-> !sysResetN [*8];
   endproperty
   a_hold: assert property (p_hold)
      else $error("system reset released too early");

   property p_divSwitch;
      $changed(divSel) |-> $past(sysTick) || $past(rstState_r == RST_HOLD);
   endproperty
   a_divSwitch: assert property (p_divSwitch)
      else $error("divider changed mid-period");

endmodule : scr_clock_reset

// ---- rtl/scr_map.svh ----
// constants of the system clock and reset block: offsets, resets, timing
// assumes a single 10 MHz clock that stands in for the oscillator sources
//
// What this block does
// - two separate rate sources, one for system clock, one for timer.
// - system clock derives from the 8 MHz system rc oscillator.
// - divider offers eight settings, 8 MHz down to 62.5 kHz, halving.
// - timer rc oscillator runs at 32.768 kHz and clocks the timer unit.
// - timer rc oscillator has no disable; nothing can stop it.
// - every reset returns the divider to the 500 kHz setting.
// - per-peripheral enables pass or block the system clock.
// - temperature sensor clock is fixed, independent of divider setting.
// - reset from external pin, watchdog or software request.
// - peripheral registers are word aligned, full-word access only.
// - 512 kB peripheral region split into 16 kB slots per peripheral.
// - only the gpio module sits on the high-speed bus.
// - external reset restores defaults; execution restarts at address 0.
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

`define SCR_CLK_HZ        10000000
`define SCR_CLK_PERIOD_NS 100
`define SCR_SYS_OSC_HZ    8000000
`define SCR_TMR_OSC_HZ    32768
`define SCR_DIV_BITS      3
`define SCR_DIV_CNT_W     7
`define SCR_DIV_RESET     3'h4
`define SCR_TEMP_DIV      4'h8
`define SCR_RST_HOLD_NS   1000
`define SCR_RST_HOLD_CYC  \
   ((`SCR_RST_HOLD_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_WAKE_LOW_US   100
`define SCR_BOOT_ADDR     32'h0000_0000
`define SCR_APB_BASE      32'h4000_0000
`define SCR_APB_SPAN_BITS 19
`define SCR_SLOT_BITS     14
`define SCR_GPIO_BASE     32'h5000_0000
`define SCR_GPIO_SPAN_BITS 14
`define SCR_SIZE_WORD     2'h2
`define SCR_GATE_RESET    32'h0000_0000

`endif

// ---- rtl/scr_pkg.sv ----
// types shared by the system clock and reset block
// assumes nothing outside itself
package scr_pkg;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0]  size;
      logic        valid;
   } scr_bus_req_t;

   typedef struct packed {
      logic pinN;
      logic wdt;
      logic sw;
   } scr_rst_src_t;

   typedef enum logic {RST_HOLD, RST_RUN} scr_rst_state_t;

endpackage : scr_pkg

// ---- rtl/scr_rate_gen.sv ----
// fractional rate source: one-cycle tick at NUM/DEN of the clock rate
// assumes NUM below DEN; stands in for a free-running rc oscillator
`timescale 1ns/1ps
module scr_rate_gen import scr_pkg::*; #(
   parameter int NUM   = 8,
   parameter int DEN   = 10,
   parameter int ACC_W = 24
) (
   input  wire logic clk,
   input  wire logic rstn,
   output logic      tick
);
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W:0]   sum;

   if (NUM <= 0 || NUM >= DEN || DEN >= (1 << ACC_W)) begin : g_badRatio
      $error("scr_rate_gen: NUM/DEN out of range");
   end

   assign sum = (ACC_W+1)'(acc_r) + (ACC_W+1)'(NUM);

   // no enable input at all: once out of reset it always runs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         acc_r <= '0;
         tick  <= 1'b0;
      end else if (sum >= (ACC_W+1)'(DEN)) begin
         acc_r <= ACC_W'(sum - (ACC_W+1)'(DEN));
         tick  <= 1'b1;
      end else begin
         acc_r <= sum[ACC_W-1:0];
         tick  <= 1'b0;
      end
   end

endmodule : scr_rate_gen

// ---- test/testbench.sv ----
// self-checking bench for the system clock, gate, reset and decode block
// assumes rtl/scr_map.svh on the include path and scr_pkg compiled first
`timescale 1ns/1ps
`include "scr_map.svh"
module testbench import scr_pkg::*;;
   localparam int NGATE = 16;
   logic              clk;
   logic              rstn;
   scr_rst_src_t      rstSrc;
   logic [2:0]        divSelReq;
   logic [NGATE-1:0]  gateReq;
   scr_bus_req_t      busReq;
   logic              sysClkEn;
   logic [NGATE-1:0]  periphClkEn;
   logic              tempClkEn;
   logic              timerClkEn;
   logic [2:0]        divSel;
   logic              sysResetN;
   logic              cpuRestart;
   logic [31:0]       bootAddr;
   logic [2:0]        rstCause;
   logic [31:0]       apbSel;
   logic              gpioSel;
   logic              busErr;
   int                n_fail;
   int                num_checks;
   int                nTimer;

   scr_clock_reset #(.NGATE(NGATE)) i_dut (
      .clk(clk), .rstn(rstn), .rstSrc(rstSrc), .divSelReq(divSelReq),
      .gateReq(gateReq), .busReq(busReq), .sysClkEn(sysClkEn),
      .periphClkEn(periphClkEn), .tempClkEn(tempClkEn),
      .timerClkEn(timerClkEn), .divSel(divSel), .sysResetN(sysResetN),
      .cpuRestart(cpuRestart), .bootAddr(bootAddr), .rstCause(rstCause),
      .apbSel(apbSel), .gpioSel(gpioSel), .busErr(busErr));

   always #(`SCR_CLK_PERIOD_NS / 2) clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic check_range(input int n, input int lo, input int hi);
      check({31'h0, (n >= lo && n <= hi)}, 32'h1);
   endtask : check_range

   task report_and_stop;
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   // waits for system reset release; returns cycles waited
   task automatic wait_run(output int c);
      c = 0;
      while (sysResetN !== 1'b1 && c < 40) begin
         @(negedge clk);
         c++;
      end
      check({31'h0, cpuRestart}, 32'h1);
      check(bootAddr, `SCR_BOOT_ADDR);
      @(negedge clk);
      check({31'h0, cpuRestart}, 32'h0);
   endtask : wait_run

   task automatic test_por;
      int c;
      repeat (4) @(posedge clk);
      check({29'h0, divSel}, {29'h0, `SCR_DIV_RESET});
      check({31'h0, sysResetN}, 32'h0);
      rstn <= 1'b1;
      wait_run(c);
   endtask : test_por

   // each source held one cycle; divider asked for 8 MHz to see the override
   task automatic test_reset_sources;
      scr_rst_src_t src [3];
      int c;
      src[0] = '{pinN: 1'b0, wdt: 1'b0, sw: 1'b0};
      src[1] = '{pinN: 1'b1, wdt: 1'b1, sw: 1'b0};
      src[2] = '{pinN: 1'b1, wdt: 1'b0, sw: 1'b1};
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         divSelReq <= 3'h0;
         rstSrc <= src[i];
         @(posedge clk);
         rstSrc <= '{pinN: 1'b1, wdt: 1'b0, sw: 1'b0};
         @(negedge clk);
         check({31'h0, sysResetN}, 32'h0);
         check({29'h0, rstCause}, 32'h4 >> i);
         @(negedge clk);
         check({29'h0, divSel}, {29'h0, `SCR_DIV_RESET});
         // gates clear one edge into hold, so the pulse after that is empty
         @(negedge clk);
         check({16'h0, periphClkEn}, 32'h0);
         wait_run(c);
         check_range(c + 2, 9, 11);
      end
      // timer keeps ticking while the system is held in reset
      @(posedge clk);
      rstSrc <= '{pinN: 1'b1, wdt: 1'b0, sw: 1'b1};
      nTimer = 0;
      repeat (2000) begin
         @(negedge clk);
         if (timerClkEn === 1'b1) nTimer++;
      end
      check_range(nTimer, 6, 7);
      @(posedge clk);
      rstSrc <= '{pinN: 1'b1, wdt: 1'b0, sw: 1'b0};
      wait_run(c);
   endtask : test_reset_sources

   // all eight divider settings, 4000 cycles each; osc ticks 8 of 10 cycles
   task automatic test_divider;
      logic [NGATE-1:0] g [8];
      int nSys, nTemp, nPair, nGateBad, c;
      logic prev;
      g = '{16'hA5C3, 16'hFFFF, 16'h0000, 16'h8001,
            16'h5A3C, 16'h0001, 16'hFFFE, 16'h8000};
      nTimer = 0;
      for (int d = 0; d < 8; d++) begin
         @(posedge clk);
         divSelReq <= d[2:0];
         gateReq <= g[d];
         c = 0;
         while (divSel !== d[2:0] && c < 600) begin
            @(negedge clk);
            c++;
         end
         check({29'h0, divSel}, d);
         nSys = 0; nTemp = 0; nPair = 0; nGateBad = 0; prev = 1'b0;
         repeat (4000) begin
            @(negedge clk);
            if (sysClkEn === 1'b1) nSys++;
            if (sysClkEn === 1'b1 && prev) nPair++;
            prev = (sysClkEn === 1'b1);
            if (tempClkEn === 1'b1) nTemp++;
            if (timerClkEn === 1'b1) nTimer++;
            if (periphClkEn !== ({NGATE{sysClkEn}} & g[d])) nGateBad++;
         end
         check_range(nSys, (3200 >> d) - 1, (3200 >> d) + 1);
         check_range(nTemp, 399, 401);
         check(nGateBad, 0);
         if (d > 0) check(nPair, 0);
      end
      check_range(nTimer, 104, 106);
   endtask : test_divider

   task automatic bus_access(input logic [31:0] a, input logic [1:0] sz,
                             input logic [31:0] eSel, input logic eGpio,
                             input logic eErr);
      @(posedge clk);
      busReq <= '{addr: a, size: sz, valid: 1'b1};
      @(negedge clk);
      @(negedge clk);
      check(apbSel, eSel);
      check({31'h0, gpioSel}, {31'h0, eGpio});
      check({31'h0, busErr}, {31'h0, eErr});
   endtask : bus_access

   // back to back: valid stays high from one access to the next
   task automatic test_bus;
      bus_access(32'h4000_8000, `SCR_SIZE_WORD, 32'h0000_0004, 1'b0, 1'b0);
      bus_access(32'h4000_0000, `SCR_SIZE_WORD, 32'h0000_0001, 1'b0, 1'b0);
      bus_access(32'h4007_FFFC, `SCR_SIZE_WORD, 32'h8000_0000, 1'b0, 1'b0);
      bus_access(32'h5000_0010, `SCR_SIZE_WORD, 32'h0, 1'b1, 1'b0);
      bus_access(32'h4000_4000, 2'h1, 32'h0, 1'b0, 1'b1);
      bus_access(32'h4000_4000, 2'h0, 32'h0, 1'b0, 1'b1);
      bus_access(32'h4000_4002, `SCR_SIZE_WORD, 32'h0, 1'b0, 1'b1);
      bus_access(32'h4008_0000, `SCR_SIZE_WORD, 32'h0, 1'b0, 1'b1);
      bus_access(32'h5000_4000, `SCR_SIZE_WORD, 32'h0, 1'b0, 1'b1);
      bus_access(32'h6000_0000, `SCR_SIZE_WORD, 32'h0, 1'b0, 1'b1);
      @(posedge clk);
      busReq <= '0;
      @(negedge clk);
      @(negedge clk);
      check(apbSel, 32'h0);
      check({30'h0, gpioSel, busErr}, 32'h0);
   endtask : test_bus

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      rstSrc = '{pinN: 1'b1, wdt: 1'b0, sw: 1'b0};
      divSelReq = `SCR_DIV_RESET;
      gateReq = '0;
      busReq = '0;
      n_fail = 0;
      num_checks = 0;
      test_por();
      test_bus();
      test_divider();
      test_reset_sources();
      report_and_stop();
   end

   // run is about 34k cycles; allow 90k, roughly two and a half times that
   initial begin
      #(`SCR_CLK_PERIOD_NS * 90000);
      n_fail++;
      report_and_stop();
   end
endmodule : testbench
